// ===== core/rse_params.svh
`ifndef RSE_PARAMS_SVH
`define RSE_PARAMS_SVH
`define RSE_BYTE_ONES 8'hFF
`define RSE_BYTE_ZERO 8'h00
`define RSE_BYTE_ONE 8'h01
`define RSE_PC_RESET 10'h000
`define RSE_PC_ONE 10'h001
`endif

// ===== core/rse_pkg.sv
package rse_pkg;
    typedef enum logic [4:0] {
        RSE_OP_NONE = 5'h00, RSE_OP_ROTL_SPILL_MEM = 5'h01, RSE_OP_ROTL_SPILL_ACC = 5'h02,
        RSE_OP_ROTR_MEM = 5'h03, RSE_OP_ROTR_ACC = 5'h04, RSE_OP_ROTR_SPILL_MEM = 5'h05,
        RSE_OP_ROTR_SPILL_ACC = 5'h06, RSE_OP_DEC_SKIP_MEM = 5'h07, RSE_OP_DEC_SKIP_ACC = 5'h08,
        RSE_OP_SET_BYTE = 5'h09, RSE_OP_INC_SKIP_MEM = 5'h0a, RSE_OP_INC_SKIP_ACC = 5'h0b,
        RSE_OP_SKIP_BIT_NZ = 5'h0c, RSE_OP_RET_INT = 5'h0d, RSE_OP_SUB_BORROW_ACC = 5'h0e,
        RSE_OP_SUB_BORROW_MEM = 5'h0f, RSE_OP_OR_ACC = 5'h10, RSE_OP_OR_IMM_ACC = 5'h11,
        RSE_OP_OR_MEM = 5'h12
    } rse_op_t;
    typedef enum logic [1:0] {RSE_ST_EXEC = 2'b01, RSE_ST_DUMMY = 2'b10} rse_state_t;
    typedef struct packed {
        logic valid;
        rse_op_t op;
        logic [7:0] mem_data;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [9:0] stack_top;
    } rse_req_t;
    typedef struct packed {
        logic spill;
        logic half_spill;
        logic zero;
        logic signed_range;
    } rse_flags_t;
    typedef struct packed {
        rse_state_t st;
        logic [7:0] accum;
        rse_flags_t flags;
        logic global_interrupt_enable;
        logic mem_we;
        logic [7:0] mem_wdata;
        logic discard_prefetch;
        logic busy;
        logic pc_load;
        logic [9:0] pc_value;
        logic done;
    } rse_state_all_t;
endpackage

// ===== core/rse_exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "rse_params.svh"
module rse_exec_unit (
    input wire logic ref_clk, // 200 MHz core clock
    input wire logic reset, // synchronous, active high
    input wire rse_pkg::rse_req_t req, // one-cycle instruction with memory operand
    output logic [7:0] accum, // accumulator
    output rse_pkg::rse_flags_t flags, // status flags
    output logic global_interrupt_enable, // master interrupt enable
    output logic mem_we, // one-cycle memory write strobe
    output logic [7:0] mem_wdata, // memory write data
    output logic discard_prefetch, // one-cycle drop of prefetched instruction
    output logic busy, // high in the dummy cycle, sequencer holds
    output logic pc_load, // one-cycle program counter load
    output logic [9:0] pc_value, // value for program counter load
    output logic done // one-cycle instruction complete
);
    // all state lives in one packed struct so reset and update stay in one place
    rse_pkg::rse_state_all_t s;
    rse_pkg::rse_state_all_t next_s;
    // how an instruction moves through the unit:
    //   the sequencer presents one request for one cycle, with the memory
    //   byte already read; the unit takes it on the next edge when it is in
    //   the exec state.
    //   every result (accumulator, flags, write strobe, program counter load)
    //   appears on the cycle after the take and comes straight from the
    //   state register, so the sequencer sees no combinational path back.
    //   a skip that is taken raises discard_prefetch and busy for one cycle;
    //   the prefetched word is thrown away by the sequencer during that cycle
    //   and done arrives one cycle later than for a plain instruction.
    //   a request that arrives while busy is high is dropped without a trace;
    //   the sequencer is expected to hold its next fetch in that cycle anyway.
    // limitations worth knowing:
    //   only one instruction is ever in flight, so there is no forwarding
    //   between a memory write and the next read of the same address: the
    //   sequencer must present the fresh byte itself.
    //   flag changes land at the take even when a skip follows, since the
    //   dummy cycle carries no work of its own.
    //   an unknown operation code raises nothing at all, not even done, so a
    //   decode fault upstream shows as a stall rather than a wrong result.
    // the dummy cycle is a state of its own rather than a counter, which keeps
    // the two-cycle timing visible in the state code and costs two flip-flops.
    // decode and execute; requests arriving in the dummy cycle are ignored
    always_comb begin
        logic [7:0] m;
        logic [7:0] r;
        logic [8:0] sum;
        logic [4:0] low;
        logic take;
        m = req.mem_data;
        r = `RSE_BYTE_ZERO;
        sum = 9'h000;
        low = 5'h00;
        take = 1'b0;
        next_s = s;
        next_s.mem_we = 1'b0;
        next_s.discard_prefetch = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.done = 1'b0;
        case (s.st)
            rse_pkg::RSE_ST_EXEC: begin
                if (req.valid) begin
                    next_s.done = 1'b1;
                    // first pass: compute the result byte, flags and skip
                    // condition; where the result goes is decided below
                    case (req.op)
                        // left rotate through spill: bit 7 out, old spill in
                        rse_pkg::RSE_OP_ROTL_SPILL_MEM,
                        rse_pkg::RSE_OP_ROTL_SPILL_ACC: begin
                            r = {m[6:0], s.flags.spill};
                            next_s.flags.spill = m[7];
                        end
                        // plain right rotate: a closed ring, flags untouched
                        rse_pkg::RSE_OP_ROTR_MEM,
                        rse_pkg::RSE_OP_ROTR_ACC: begin
                            r = {m[0], m[7:1]};
                        end
                        // nine-bit ring: spill sits above bit 7
                        rse_pkg::RSE_OP_ROTR_SPILL_MEM,
                        rse_pkg::RSE_OP_ROTR_SPILL_ACC: begin
                            r = {s.flags.spill, m[7:1]};
                            next_s.flags.spill = m[0];
                        end
                        // decrement wraps from zero to all ones without a flag
                        rse_pkg::RSE_OP_DEC_SKIP_MEM,
                        rse_pkg::RSE_OP_DEC_SKIP_ACC: begin
                            r = m - `RSE_BYTE_ONE;
                            take = (r == `RSE_BYTE_ZERO);
                        end
                        // increment skips only on the wrap from all ones
                        rse_pkg::RSE_OP_INC_SKIP_MEM,
                        rse_pkg::RSE_OP_INC_SKIP_ACC: begin
                            r = m + `RSE_BYTE_ONE;
                            take = (r == `RSE_BYTE_ZERO);
                        end
                        // set byte ignores the operand entirely
                        rse_pkg::RSE_OP_SET_BYTE: begin
                            r = `RSE_BYTE_ONES;
                        end
                        // bit test writes nothing; only the skip path moves
                        rse_pkg::RSE_OP_SKIP_BIT_NZ: begin
                            take = m[req.bit_sel];
                        end
                        // return reloads the counter and reopens interrupts
                        // together, so no interrupt can slip in between
                        rse_pkg::RSE_OP_RET_INT: begin
                            next_s.pc_load = 1'b1;
                            next_s.pc_value = req.stack_top;
                            next_s.global_interrupt_enable = 1'b1;
                        end
                        rse_pkg::RSE_OP_SUB_BORROW_ACC,
                        rse_pkg::RSE_OP_SUB_BORROW_MEM: begin
                            // spill set means no borrow, so it adds straight in
                            sum = {1'b0, s.accum} + {1'b0, ~m} + {8'h00, s.flags.spill};
                            low = {1'b0, s.accum[3:0]} + {1'b0, ~m[3:0]}
                                + {4'h0, s.flags.spill};
                            r = sum[7:0];
                            next_s.flags.spill = sum[8];
                            next_s.flags.half_spill = low[4];
                            next_s.flags.zero = (sum[7:0] == `RSE_BYTE_ZERO);
                            next_s.flags.signed_range = (s.accum[7] == ~m[7])
                                && (sum[7] != s.accum[7]);
                        end
                        // or forms touch only the zero flag
                        rse_pkg::RSE_OP_OR_ACC,
                        rse_pkg::RSE_OP_OR_MEM: begin
                            r = s.accum | m;
                            next_s.flags.zero = (r == `RSE_BYTE_ZERO);
                        end
                        rse_pkg::RSE_OP_OR_IMM_ACC: begin
                            r = s.accum | req.imm;
                            next_s.flags.zero = (r == `RSE_BYTE_ZERO);
                        end
                        // unknown or empty code: no result, no done
                        default: begin
                            next_s.done = 1'b0;
                        end
                    endcase
                    // route result to memory or accumulator per variant
                    case (req.op)
                        rse_pkg::RSE_OP_ROTL_SPILL_MEM, rse_pkg::RSE_OP_ROTR_MEM,
                        rse_pkg::RSE_OP_ROTR_SPILL_MEM, rse_pkg::RSE_OP_DEC_SKIP_MEM,
                        rse_pkg::RSE_OP_INC_SKIP_MEM, rse_pkg::RSE_OP_SET_BYTE,
                        rse_pkg::RSE_OP_SUB_BORROW_MEM, rse_pkg::RSE_OP_OR_MEM: begin
                            next_s.mem_we = 1'b1;
                            next_s.mem_wdata = r;
                        end
                        rse_pkg::RSE_OP_ROTL_SPILL_ACC, rse_pkg::RSE_OP_ROTR_ACC,
                        rse_pkg::RSE_OP_ROTR_SPILL_ACC, rse_pkg::RSE_OP_DEC_SKIP_ACC,
                        rse_pkg::RSE_OP_INC_SKIP_ACC, rse_pkg::RSE_OP_SUB_BORROW_ACC,
                        rse_pkg::RSE_OP_OR_ACC, rse_pkg::RSE_OP_OR_IMM_ACC: begin
                            next_s.accum = r;
                        end
                        default: begin
                            next_s.mem_we = 1'b0;
                        end
                    endcase
                    // a taken skip costs one dummy cycle; done moves to its end
                    if (take) begin
                        next_s.discard_prefetch = 1'b1;
                        next_s.busy = 1'b1;
                        next_s.done = 1'b0;
                        next_s.st = rse_pkg::RSE_ST_DUMMY;
                    end
                end
            end
            // dummy cycle: no work, the request on the bus is dropped
            rse_pkg::RSE_ST_DUMMY: begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.st = rse_pkg::RSE_ST_EXEC;
            end
            // an illegal state code falls back to exec rather than locking up
            default: begin
                next_s.st = rse_pkg::RSE_ST_EXEC;
                next_s.busy = 1'b0;
            end
        endcase
    end
    // single state register; reset clears everything to idle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= '0;
            s.st <= rse_pkg::RSE_ST_EXEC;
            s.pc_value <= `RSE_PC_RESET;
        end else begin
            s <= next_s;
        end
    end
    // every output is a plain view of the state register
    assign accum = s.accum;
    assign flags = s.flags;
    assign global_interrupt_enable = s.global_interrupt_enable;
    assign mem_we = s.mem_we;
    assign mem_wdata = s.mem_wdata;
    assign discard_prefetch = s.discard_prefetch;
    assign busy = s.busy;
    assign pc_load = s.pc_load;
    assign pc_value = s.pc_value;
    assign done = s.done;
endmodule // rse_exec_unit
`default_nettype wire

// ===== verification/rse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// data memory byte on the far side; counts writes so a stray or missing strobe shows
module rse_mem_model (
    input wire logic ref_clk, // core clock
    input wire logic mem_we, // write strobe
    input wire logic [7:0] mem_wdata, // write data
    output var logic [7:0] rd, // stored byte
    output var int n_wr // writes taken
);
    // one write per strobe cycle, no read-modify hazard modelled
    always @(posedge ref_clk) begin
        if (mem_we) begin
            rd <= mem_wdata;
            n_wr <= n_wr + 1;
        end
    end
    initial n_wr = 0;
endmodule // rse_mem_model
`default_nettype wire

// ===== verification/rse_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rse_exec_chk (
    input wire logic ref_clk, // clock
    input wire logic reset, // sync reset
    input wire rse_pkg::rse_req_t req, // request
    input wire logic [7:0] accum, // accumulator
    input wire rse_pkg::rse_flags_t flags, // flags
    input wire logic global_interrupt_enable, // interrupt enable
    input wire logic mem_we, // write strobe
    input wire logic [7:0] mem_wdata, // write data
    input wire logic discard_prefetch, // skip strobe
    input wire logic busy, // dummy cycle
    input wire logic pc_load, // pc load
    input wire logic [9:0] pc_value, // pc value
    input wire logic done // complete
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic go;
    logic [7:0] m;
    rse_pkg::rse_op_t op;
    // a request counts only outside the dummy cycle
    assign go = req.valid && !busy;
    assign m = req.mem_data;
    assign op = req.op;
    chk_rotl_spill: assert property (go && op == rse_pkg::RSE_OP_ROTL_SPILL_MEM |=> mem_we
        && mem_wdata == {$past(m[6:0]), $past(flags.spill)} && flags.spill == $past(m[7]))
        else $error("rotate left through spill wrong");
    chk_rotr_acc: assert property (go && op == rse_pkg::RSE_OP_ROTR_ACC |=> !mem_we
        && accum == {$past(m[0]), $past(m[7:1])}) else $error("rotate right to accum wrong");
    chk_flags_kept: assert property (go && op inside {rse_pkg::RSE_OP_ROTR_MEM,
        rse_pkg::RSE_OP_SET_BYTE} |=> flags == $past(flags)) else $error("flags changed");
    chk_set_ones: assert property (go && op == rse_pkg::RSE_OP_SET_BYTE |=> mem_we
        && mem_wdata == 8'hff) else $error("set byte wrong");
    chk_dec_skip: assert property (go && op == rse_pkg::RSE_OP_DEC_SKIP_MEM |=> mem_we
        && mem_wdata == $past(m) - 8'h01 && discard_prefetch == ($past(m) == 8'h01))
        else $error("decrement skip wrong");
    chk_inc_acc: assert property (go && op == rse_pkg::RSE_OP_INC_SKIP_ACC |=> !mem_we
        && accum == $past(m) + 8'h01 && discard_prefetch == ($past(m) == 8'hff))
        else $error("increment to accum wrong");
    chk_skip_two: assert property (discard_prefetch |-> busy && !done ##1 done && !busy)
        else $error("skip timing wrong");
    chk_bit_skip: assert property (go && op == rse_pkg::RSE_OP_SKIP_BIT_NZ |=> !mem_we
        && discard_prefetch == $past(m[req.bit_sel])) else $error("bit skip wrong");
    chk_ret_pc: assert property (go && op == rse_pkg::RSE_OP_RET_INT |=> pc_load
        && pc_value == $past(req.stack_top) && global_interrupt_enable) else $error("return wrong");
    cov_skip: cover property (discard_prefetch);
    cov_refused: cover property (req.valid && busy);
    cov_pc: cover property (pc_load);
endmodule // rse_exec_chk
bind rse_exec_unit rse_exec_chk u_chk (.ref_clk, .reset, .req, .accum, .flags,
    .global_interrupt_enable, .mem_we, .mem_wdata, .discard_prefetch, .busy, .pc_load,
    .pc_value, .done);
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    rse_pkg::rse_req_t req = '0;
    rse_pkg::rse_flags_t flags;
    logic [7:0] accum, mem_wdata, rd, acc = 8'h00, wd = 8'h00;
    logic gie, mem_we, discard_prefetch, busy, pc_load, done, c = 1'b0, sk = 1'b0, wr = 1'b0;
    logic [9:0] pc_value, st = 10'h000;
    logic [18:0] q[$];
    int n_errors = 0, n_tests = 0, n_wr, exp_wr = 0, seed = 77631;
    rse_exec_unit dut (.ref_clk, .reset, .req, .accum, .flags, .global_interrupt_enable(gie),
        .mem_we, .mem_wdata, .discard_prefetch, .busy, .pc_load, .pc_value, .done);
    rse_mem_model mem (.ref_clk, .mem_we, .mem_wdata, .rd, .n_wr);
    always #2.5 ref_clk = ~ref_clk;
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // model the instruction, note the expected outcome, then drive it
    task automatic issue(input rse_pkg::rse_op_t op, input logic [7:0] m, input logic [2:0] bs);
        logic [7:0] r;
        logic s;
        logic w;
        r = acc;
        s = 1'b0;
        case (op)
            rse_pkg::RSE_OP_ROTL_SPILL_MEM, rse_pkg::RSE_OP_ROTL_SPILL_ACC: begin
                r = {m[6:0], c};
                c = m[7];
            end
            rse_pkg::RSE_OP_ROTR_MEM, rse_pkg::RSE_OP_ROTR_ACC: r = {m[0], m[7:1]};
            rse_pkg::RSE_OP_ROTR_SPILL_MEM, rse_pkg::RSE_OP_ROTR_SPILL_ACC: begin
                r = {c, m[7:1]};
                c = m[0];
            end
            rse_pkg::RSE_OP_DEC_SKIP_MEM, rse_pkg::RSE_OP_DEC_SKIP_ACC: r = m - 8'h01;
            rse_pkg::RSE_OP_INC_SKIP_MEM, rse_pkg::RSE_OP_INC_SKIP_ACC: r = m + 8'h01;
            rse_pkg::RSE_OP_SET_BYTE: r = 8'hff;
            rse_pkg::RSE_OP_SKIP_BIT_NZ: s = m[bs];
            default: ;
        endcase
        if (op inside {5'h07, 5'h08, 5'h0a, 5'h0b})
            s = (r == 8'h00);
        w = op inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0a};
        if (w)
            wd = r;
        else if (op inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h0b})
            acc = r;
        q.push_back({s, w, wd, c, acc});
        exp_wr += w;
        @(posedge ref_clk);
        #1;
        st = 10'($random(seed));
        req = {1'b1, op, m, 8'h00, bs, st};
        // in the dummy cycle a set-byte request may arrive and must be dropped
        if (s) begin
            @(posedge ref_clk);
            #1;
            req.op = rse_pkg::RSE_OP_SET_BYTE;
            req.valid = 1'($random(seed));
        end
    endtask
    // results gather until done, since a skip delays done by one cycle
    always @(posedge ref_clk) begin
        if (done)
            check({sk, wr | mem_we, mem_wdata, flags.spill, accum}, q.pop_front());
        sk <= done ? 1'b0 : sk | discard_prefetch;
        wr <= done ? 1'b0 : wr | mem_we;
    end
    initial begin
        int v;
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 400; i++) begin
            v = $random(seed);
            issue(rse_pkg::rse_op_t'(5'(v[7:0] % 8'h0d) + 5'h01), v[9:8] == 2'h0 ? 8'h01 :
                (v[9:8] == 2'h1 ? {8{v[10]}} : v[31:24]), v[14:12]);
        end
        issue(rse_pkg::RSE_OP_RET_INT, 8'h00, 3'h0);
        @(posedge ref_clk);
        #1 req.valid = 1'b0;
        repeat (4) @(posedge ref_clk);
        check({9'h000, pc_value}, {9'h000, st});
        check(19'(gie), 19'h1);
        check(19'(rd), 19'(wd));
        check(19'(n_wr), 19'(exp_wr));
        check(19'(q.size()), 19'h0);
        results();
    end
    // at most about 800 cycles of traffic (two per instruction if every one skips); give four times that
    initial begin
        #16000;
        n_errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
